// >>> logic/adcf_pkg.sv
// Shared constants and types of the converter serial framing block
`default_nettype none
package adcf_pkg;
  // Result word layout: sign plus twelve data bits
  localparam int RES_W  = 12;
  localparam int WORD_W = 13;
  // Raw converter value, wide enough to show overrange both ways
  localparam int RAW_W  = 14;

  // Saturation limits of the two's complement result
  localparam logic [12:0] POS_FULL  = 13'h0fff;
  localparam logic [12:0] NEG_FULL  = 13'h1000;
  localparam logic [12:0] WORD_ZERO = 13'h0000;

  // Rising-edge counts after the start bit
  localparam logic [5:0] CNT_ZERO     = 6'h00;
  localparam logic [5:0] CNT_CMD_LAST = 6'h03;
  localparam logic [5:0] CNT_MAX      = 6'h3f;
  // Falling-edge actions, keyed by rising edges seen so far
  localparam logic [5:0] FALL_SMP_END = 6'h05;
  localparam logic [5:0] FALL_NULL    = 6'h06;
  localparam logic [5:0] FALL_SIGN    = 6'h07;
  localparam logic [5:0] FALL_MSB_END = 6'h13;
  localparam logic [5:0] FALL_LSB_END = 6'h1f;

  // Buffer depth in front of the framer
  localparam int BUF_DEPTH = 2;

  // Framing states, one-hot
  typedef enum logic [3:0] {
    ST_WAIT_HIGH  = 4'h1,
    ST_WAIT_START = 4'h2,
    ST_CMD        = 4'h4,
    ST_XFER       = 4'h8
  } adcf_state_t;
endpackage
`default_nettype wire

// >>> logic/adcf_buf.sv
// Two-entry valid/ready buffer holding converter results
`default_nettype none
module adcf_buf #(
  parameter int W     = 14,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         flush_in,
  // Filling side
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  // Draining side
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  // Pointers are one bit wide, so only two entries can be served
  if (DEPTH != 2 || W < 1) begin
    $error("adcf_buf serves exactly two entries of nonzero width");
  end

  logic [W-1:0] mem_r [DEPTH];
  logic         wr_ptr_r;
  logic         rd_ptr_r;
  logic [1:0]   cnt_r;
  logic [1:0]   cnt_nxt;
  logic         push;
  logic         pop;

  // Handshakes on both sides
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_ready_in && out_valid_out;
  assign out_data_out = mem_r[rd_ptr_r];

  // Occupancy after this cycle
  always_comb begin
    cnt_nxt = cnt_r;
    if (flush_in) begin
      cnt_nxt = 2'h0;
    end else if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  // Count and flags kept in flip-flops so ready is honest
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_r         <= 2'h0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      cnt_r         <= cnt_nxt;
      in_ready_out  <= (cnt_nxt != 2'h2);
      out_valid_out <= (cnt_nxt != 2'h0);
    end
  end

  // Pointers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || flush_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk_in) begin
    if (push && !flush_in) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  // Full buffer must refuse new words
  buf_full_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cnt_r == 2'h2) |-> !in_ready_out)
    else $error("buffer full but ready");
endmodule
`default_nettype wire

// >>> logic/adcf_frame.sv
// Serial command and result framing of a 13-bit differential converter
// Functional notes
// - Result is two's complement; sign 0 when positive input is higher.
// - Result saturates at +4095 and -4096.
// - Transaction starts on select falling; after power-up low, select must rise first.
// - First clock with select low and command input high is the start bit.
// - Mode bit follows start bit: 1 single-ended, 0 differential.
// - Three channel bits follow, high, middle, low.
// - Eight-input map: binary channels, or pairs with low bit giving polarity.
// - Four-input variant ignores the high select bit.
// - Single-ended results are unipolar; sign bit always sent as 0.
// - Sampling starts on fourth rising edge, ends on fifth clock's falling edge.
// - One more clock finishes sampling; command input ignored then.
// - Falling edge of the next clock drives a low null bit.
// - Next 13 clocks send sign then twelve data bits, MSB first.
// - Output data changes only on falling clock edges.
// - Further clocks repeat the result LSB first.
// - After the LSB-first repeat, zeros are sent while clocks continue.
// - Once only shifting remains, comparator and bias power down.
// - Output stays high-impedance until the null bit.
// - Works with clock idling low or high; sample rise, change fall.
`default_nettype none
module adcf_frame #(
  parameter bit EIGHT_INPUT = 1'b1,
  parameter int RAW_WIDTH   = adcf_pkg::RAW_W
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 sys_rst_in,
  // Serial pins from the host
  input  wire logic                 cs_n_in,
  input  wire logic                 sclk_in,
  input  wire logic                 din_in,
  // Serial data pin, two signals: data and output enable
  output logic                      dout_out,
  output logic                      dout_oe_out,
  // Raw result stream from the converter core
  input  wire logic                 raw_valid_in,
  input  wire logic [RAW_WIDTH-1:0] raw_data_in,
  output logic                      raw_ready_out,
  // Control toward the analog core
  output logic                      sample_out,
  output logic                      conv_start_out,
  output logic                      single_out,
  output logic [2:0]                chan_pos_out,
  output logic [2:0]                chan_neg_out,
  output logic                      bias_en_out
);
  // Saturation logic serves exactly the package raw width
  if (RAW_WIDTH != adcf_pkg::RAW_W) begin
    $error("adcf_frame needs a raw width of 14");
  end

  // Saturate a raw value into the 13-bit result word
  function automatic logic [12:0] sat_word(input logic signed [13:0] raw,
                                           input logic single);
    logic [12:0] w;
    w = raw[12:0];
    if (raw > 14'sh0fff) begin
      w = adcf_pkg::POS_FULL;
    end else if (raw < -14'sh1000) begin
      w = adcf_pkg::NEG_FULL;
    end
    if (single && w[12]) begin
      w = adcf_pkg::WORD_ZERO;
    end
    return w;
  endfunction

  // Channel mapping; returns {positive, negative}
  function automatic logic [5:0] chan_map(input logic [3:0] cmd);
    logic [2:0] sel;
    sel = EIGHT_INPUT ? cmd[2:0] : {1'b0, cmd[1:0]};
    if (cmd[3]) begin
      return {sel, 3'h0};
    end
    return {sel[2:1], sel[0], sel[2:1], ~sel[0]};
  endfunction

  // Two-stage synchronisers; select resets low so one held low since power-up must rise first
  logic cs_m;
  logic cs_s;
  logic sclk_m;
  logic sclk_s;
  logic sclk_d;
  logic din_m;
  logic din_s;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cs_m   <= 1'b0;
      cs_s   <= 1'b0;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      din_m  <= 1'b0;
      din_s  <= 1'b0;
    end else begin
      cs_m   <= cs_n_in;
      cs_s   <= cs_m;
      sclk_m <= sclk_in;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      din_m  <= din_in;
      din_s  <= din_m;
    end
  end

  // Edges of the host clock; idle level does not matter because
  // bits are counted on rising edges only
  // both idle levels
  logic rise;
  logic fall;
  assign rise = sclk_s && !sclk_d && !cs_s;
  assign fall = !sclk_s && sclk_d && !cs_s;

  adcf_pkg::adcf_state_t state_r;
  logic [5:0]  rcnt_r;
  logic [3:0]  cmd_r;
  logic [12:0] res_r;
  logic [3:0]  cmd_full;
  logic [12:0] head_word;
  logic        pop;
  logic        buf_valid;
  logic [13:0] buf_data;
  logic        flush;

  assign cmd_full  = {cmd_r[2:0], din_s};
  assign head_word = buf_valid ? sat_word(buf_data, single_out)
                               : adcf_pkg::WORD_ZERO;
  // Result is taken when the sign bit goes out
  assign pop   = fall && (state_r == adcf_pkg::ST_XFER)
              && (rcnt_r == adcf_pkg::FALL_SIGN);
  // Stale words from aborted frames are dropped at each new conversion
  assign flush = fall && (state_r == adcf_pkg::ST_XFER)
              && (rcnt_r == adcf_pkg::FALL_SMP_END);

  // Framing state machine
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r <= adcf_pkg::ST_WAIT_HIGH;
    end else if (cs_s) begin
      state_r <= adcf_pkg::ST_WAIT_START;
    end else begin
      case (state_r)
        adcf_pkg::ST_WAIT_HIGH: begin
          state_r <= adcf_pkg::ST_WAIT_HIGH;
        end
        adcf_pkg::ST_WAIT_START: begin
          if (rise && din_s) begin
            state_r <= adcf_pkg::ST_CMD;
          end
        end
        adcf_pkg::ST_CMD: begin
          if (rise && rcnt_r == adcf_pkg::CNT_CMD_LAST) begin
            state_r <= adcf_pkg::ST_XFER;
          end
        end
        adcf_pkg::ST_XFER: begin
          state_r <= adcf_pkg::ST_XFER;
        end
        default: begin
          state_r <= adcf_pkg::ST_WAIT_START;
        end
      endcase
    end
  end

  // Rising edges after the start bit, saturating so zeros run on
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || cs_s || state_r == adcf_pkg::ST_WAIT_START) begin
      rcnt_r <= adcf_pkg::CNT_ZERO;
    end else if (rise && rcnt_r != adcf_pkg::CNT_MAX) begin
      rcnt_r <= rcnt_r + 6'h01;
    end
  end

  // Command bits shift in; input after the low select bit is ignored
  // mode bit first
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cmd_r <= 4'h0;
    end else if (rise && state_r == adcf_pkg::ST_CMD) begin
      cmd_r <= cmd_full;
    end
  end

  // Channel selection latched as sampling begins
  // eight-input map
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      single_out   <= 1'b0;
      chan_pos_out <= 3'h0;
      chan_neg_out <= 3'h0;
    end else if (rise && state_r == adcf_pkg::ST_CMD
                 && rcnt_r == adcf_pkg::CNT_CMD_LAST) begin
      single_out   <= cmd_full[3];
      {chan_pos_out, chan_neg_out} <= chan_map(cmd_full);
    end
  end

  // Sample window and conversion start
  // sample window
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || cs_s) begin
      sample_out     <= 1'b0;
      conv_start_out <= 1'b0;
    end else begin
      conv_start_out <= flush;
      if (rise && state_r == adcf_pkg::ST_CMD
          && rcnt_r == adcf_pkg::CNT_CMD_LAST) begin
        sample_out <= 1'b1;
      end else if (flush) begin
        sample_out <= 1'b0;
      end
    end
  end

  // Bias stays on until the result is taken, then only shifting runs
  // power down for shifting
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || cs_s || pop) begin
      bias_en_out <= 1'b0;
    end else if (rise && state_r == adcf_pkg::ST_WAIT_START && din_s) begin
      bias_en_out <= 1'b1;
    end
  end

  // Result register, kept for the repeat
  // two's complement word
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      res_r <= adcf_pkg::WORD_ZERO;
    end else if (pop) begin
      res_r <= head_word;
    end
  end

  // Serial output, changed on falling edges only
  // falling-edge updates
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dout_out <= 1'b0;
    end else if (fall && state_r == adcf_pkg::ST_XFER) begin
      if (rcnt_r == adcf_pkg::FALL_NULL) begin
        dout_out <= 1'b0;
      end else if (rcnt_r == adcf_pkg::FALL_SIGN) begin
        dout_out <= head_word[12];
      end else if (rcnt_r > adcf_pkg::FALL_SIGN
                   && rcnt_r <= adcf_pkg::FALL_MSB_END) begin
        dout_out <= res_r[4'(adcf_pkg::FALL_MSB_END - rcnt_r)];
      end else if (rcnt_r > adcf_pkg::FALL_MSB_END
                   && rcnt_r <= adcf_pkg::FALL_LSB_END) begin
        dout_out <= res_r[4'(rcnt_r - adcf_pkg::FALL_MSB_END)];
      end else if (rcnt_r > adcf_pkg::FALL_LSB_END) begin
        dout_out <= 1'b0;
      end
    end
  end

  // Output enable, released by select high
  // float until null bit
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || cs_s) begin
      dout_oe_out <= 1'b0;
    end else if (fall && state_r == adcf_pkg::ST_XFER
                 && rcnt_r == adcf_pkg::FALL_NULL) begin
      dout_oe_out <= 1'b1;
    end
  end

  // Result buffer; its ready goes straight to the core
  adcf_buf #(
    .W     (adcf_pkg::RAW_W),
    .DEPTH (adcf_pkg::BUF_DEPTH)
  ) u_buf (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .flush_in      (flush),
    .in_valid_in   (raw_valid_in),
    .in_data_in    (raw_data_in),
    .in_ready_out  (raw_ready_out),
    .out_valid_out (buf_valid),
    .out_data_out  (buf_data),
    .out_ready_in  (pop)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  abort_float_a: assert property (cs_s |=> !dout_oe_out)
    else $error("output driven with select high");
  no_rearm_a: assert property (
    (state_r == adcf_pkg::ST_WAIT_HIGH) && !cs_s |=> state_r == adcf_pkg::ST_WAIT_HIGH)
    else $error("armed without select high");
  start_bit_a: assert property (
    (state_r == adcf_pkg::ST_WAIT_START) && rise && din_s |=> state_r == adcf_pkg::ST_CMD)
    else $error("start bit missed");
  lead_zero_a: assert property (
    (state_r == adcf_pkg::ST_WAIT_START) && rise && !din_s && !cs_s
    |=> state_r == adcf_pkg::ST_WAIT_START)
    else $error("leading zero taken");
  sample_on_a: assert property (
    (state_r == adcf_pkg::ST_CMD) && rise && rcnt_r == 6'h03 |=> sample_out ##0 !$past(sample_out))
    else $error("sampling late");
  sample_off_a: assert property (
    sample_out && flush |=> !sample_out && conv_start_out)
    else $error("sampling end wrong");
  null_bit_a: assert property (
    fall && state_r == adcf_pkg::ST_XFER && rcnt_r == 6'h06 |=> dout_oe_out && !dout_out)
    else $error("null bit wrong");
  oe_late_a: assert property (
    dout_oe_out && !$past(dout_oe_out) |-> $past(fall) && $past(rcnt_r) == 6'h06)
    else $error("output enabled early");
  change_fall_a: assert property (
    !$stable(dout_out) |-> $past(fall))
    else $error("data changed off falling edge");
  msb_first_a: assert property (
    pop |=> dout_out == res_r[12] ##0 res_r == $past(head_word))
    else $error("sign bit wrong");
  se_sign_a: assert property (pop && single_out |=> !dout_out)
    else $error("negative single-ended sign");
  sat_pos_a: assert property (
    pop && buf_valid && $signed(buf_data) > 14'sh0fff |=> res_r == 13'h0fff)
    else $error("no positive saturation");
  zeros_a: assert property (
    fall && state_r == adcf_pkg::ST_XFER && rcnt_r > 6'h1f |=> !dout_out)
    else $error("trailing data not zero");
  bias_off_a: assert property (pop |=> !bias_en_out)
    else $error("bias still on while shifting");

  start_c: cover property ((state_r == adcf_pkg::ST_WAIT_START) && rise && din_s);
  null_c: cover property (fall && state_r == adcf_pkg::ST_XFER && rcnt_r == 6'h06);
  lsb_c: cover property (fall && state_r == adcf_pkg::ST_XFER && rcnt_r == 6'h14);
  abort_c: cover property (dout_oe_out && cs_s);
endmodule
`default_nettype wire

// >>> tb/adcf_host.sv
// Host serial master model driving the converter framing pins
`default_nettype none
module adcf_host (
  // Pacing clock
  input  wire logic clk_in,
  // Serial pins toward the device
  output var logic  cs_n_out,
  output var logic  sclk_out,
  output var logic  din_out,
  input  wire logic dout_in,
  input  wire logic dout_oe_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Captured data and enable, one entry per serial clock
  logic rx_bit [0:63];
  logic rx_oe  [0:63];

  // Pins start with select low, as after a power-up
  initial begin
    cs_n_out = 1'b0;
    sclk_out = 1'b0;
    din_out  = 1'b0;
  end

  // Half a link period: 160 ns, four system clocks
  task automatic half(input int n);
    repeat (4 * n) @(posedge clk_in);
    #1;
  endtask

  // Stray clocks with select left low and data high
  task automatic stray(input int n);
    din_out = 1'b1;
    repeat (n) begin
      sclk_out = 1'b1;
      half(1);
      sclk_out = 1'b0;
      half(1);
    end
  endtask

  // One transaction; cpol picks the idle level of the clock
  task automatic frame(input logic [4:0] cmd, input int lead, input int nclk,
                       input logic cpol);
    sclk_out = cpol;
    // select high before each falling start
    cs_n_out = 1'b1;
    half(4);
    cs_n_out = 1'b0;
    half(1);
    for (int k = 0; k < nclk; k++) begin
      sclk_out = 1'b0;
      // zeros, command, then a wiggling don't-care line
      if (k < lead) din_out = 1'b0;
      else if (k - lead < 5) din_out = cmd[4 - (k - lead)];
      else din_out = ~din_out;
      half(1);
      // data changes low, device output latched while high
      sclk_out = 1'b1;
      half(1);
      rx_bit[k] = dout_in;
      rx_oe[k]  = dout_oe_in;
    end
    sclk_out = cpol;
    half(1);
    cs_n_out = 1'b1;
    half(2);
  endtask
endmodule
`default_nettype wire

// >>> tb/adcf_frame_tb.sv
// Self-checking bench of the converter serial framing block
`default_nettype none
module adcf_frame_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Design pins
  logic        clk_in, sys_rst_in, cs_n, sclk, din, dout_out, dout_oe_out;
  logic        raw_valid_in, raw_ready_out, sample_out, conv_start_out;
  logic        single_out, bias_en_out;
  logic [13:0] raw_data_in;
  logic [2:0]  chan_pos_out, chan_neg_out;
  // Bench state
  int          bad_count, checked, conv_cnt, npush, cycles, smp_cyc;
  logic [2:0]  quad_pos, quad_neg;
  logic [13:0] raw_q [0:2];
  logic [13:0] tbl [0:5] = '{14'h0fff, 14'h1fff, 14'h3000, 14'h2000, 14'h3fff, 14'h0001};

  adcf_frame #(.EIGHT_INPUT(1'b1), .RAW_WIDTH(14)) dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .din_in(din), .dout_out(dout_out), .dout_oe_out(dout_oe_out),
    .raw_valid_in(raw_valid_in), .raw_data_in(raw_data_in), .raw_ready_out(raw_ready_out),
    .sample_out(sample_out), .conv_start_out(conv_start_out), .single_out(single_out),
    .chan_pos_out(chan_pos_out), .chan_neg_out(chan_neg_out), .bias_en_out(bias_en_out));

  adcf_host host_u (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din),
    .dout_in(dout_out), .dout_oe_in(dout_oe_out));

  // Four-input variant on the same pins; only its channel map is compared
  adcf_frame #(.EIGHT_INPUT(1'b0), .RAW_WIDTH(14)) quad_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .din_in(din), .dout_out(), .dout_oe_out(), .raw_valid_in(1'b0),
    .raw_data_in(14'h0000), .raw_ready_out(), .sample_out(), .conv_start_out(),
    .single_out(), .chan_pos_out(quad_pos), .chan_neg_out(quad_neg), .bias_en_out());

  // 25 MHz system clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Expected word: saturate the raw value, clip negatives in single-ended mode
  function automatic logic [12:0] satw(input logic [13:0] r, input logic s);
    if (r[13] && s) return adcf_pkg::WORD_ZERO;
    if (!r[13] && r[12]) return adcf_pkg::POS_FULL;
    if (r[13] && !r[12]) return adcf_pkg::NEG_FULL;
    return r[12:0];
  endfunction

  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic done_test(input string s);
    $display("Test %s done: checked=%0d bad_count=%0d", s, checked, bad_count);
  endtask

  task automatic results();
    $display("Totals: checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One frame, then every sampled enable, each sampled bit from the null bit on and the control outputs are compared
  task automatic run(input logic [3:0] cmd, input int lead, input int nclk,
                     input logic cpol, input int np, input logic [12:0] w);
    int   c0;
    int   n;
    logic eb;
    npush = np;
    c0 = conv_cnt;
    host_u.frame({1'b1, cmd}, lead, nclk, cpol);
    for (int k = 0; k < nclk; k++) begin
      n = k - lead;
      eb = (n == 8 || n == 32) ? w[12] : (n >= 9 && n <= 20) ? w[20 - n] :
           (n >= 21 && n <= 31) ? w[n - 20] : 1'b0;
      cmp_bit(host_u.rx_oe[k], n >= 7);
      if (n >= 7) cmp_bit(host_u.rx_bit[k], eb);
    end
    cmp_word(13'(conv_cnt - c0), 13'h0001);
    cmp_bit(dout_oe_out, 1'b0);
    cmp_bit(bias_en_out, 1'b0);
    cmp_bit(sample_out, 1'b0);
    cmp_bit(single_out, cmd[3]);
    cmp_word({7'h00, chan_pos_out, chan_neg_out},
             {7'h00, cmd[2:0], cmd[3] ? 3'h0 : {cmd[2:1], ~cmd[0]}});
    cmp_word({7'h00, quad_pos, quad_neg},
             {8'h00, cmd[1:0], cmd[3] ? 3'h0 : {1'b0, cmd[1], ~cmd[0]}});
  endtask

  // Core model: npush words after each conversion start; the third one meets a full buffer
  initial begin
    forever begin
      @(posedge clk_in);
      if (conv_start_out === 1'b1) begin
        conv_cnt++;
        // Fourth rise to fifth fall is 1.5 link periods, 12 system cycles
        cmp_word(13'(smp_cyc), 13'h000c);
        cmp_bit(bias_en_out, 1'b1);
        smp_cyc = 0;
        for (int i = 0; i < npush; i++) begin
          #1;
          if (i == 2) cmp_bit(raw_ready_out, 1'b0);
          raw_valid_in = 1'b1;
          raw_data_in  = raw_q[i];
          @(posedge clk_in);
          while (raw_ready_out !== 1'b1) @(posedge clk_in);
        end
        #1;
        raw_valid_in = 1'b0;
      end
    end
  end

  // Hang guard, well above the roughly 7400 cycles the tests need
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk_in);
      cycles++;
      if (sample_out === 1'b1) smp_cyc++;
      if (cycles == 40000) begin
        bad_count++;
        $display("Error at %0t: timeout got %0h expected %0h", $time, cycles, 0);
        results();
      end
    end
  end

  // Main sequence
  initial begin
    sys_rst_in   = 1'b1;
    raw_valid_in = 1'b0;
    raw_data_in  = 14'h0000;
    bad_count    = 0;
    checked      = 0;
    conv_cnt     = 0;
    npush        = 1;
    smp_cyc      = 0;
    repeat (16) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    host_u.stray(6);
    cmp_word(13'(conv_cnt), 13'h0000);
    cmp_bit(dout_oe_out, 1'b0);
    done_test("power-up with select low");
    for (int i = 0; i < 16; i++) begin
      raw_q[0] = tbl[i % 6];
      run(i[3:0], i % 3, (i % 3) + 40, 1'b0, 1, satw(tbl[i % 6], i[3]));
    end
    done_test("all channel codes and limits");
    raw_q[0] = 14'h3fff;
    run(4'b0101, 6, 46, 1'b1, 1, satw(14'h3fff, 1'b0));
    done_test("clock idling high");
    raw_q = '{14'h0123, 14'h0456, 14'h0789};
    run(4'b0010, 1, 41, 1'b0, 3, 13'h0123);
    run(4'b0010, 0, 40, 1'b0, 0, adcf_pkg::WORD_ZERO);
    done_test("full buffer then empty buffer");
    raw_q[0] = 14'h0aaa;
    run(4'b0011, 0, 12, 1'b0, 1, 13'h0aaa);
    raw_q[0] = 14'h1555;
    run(4'b0011, 2, 42, 1'b0, 1, 13'h0fff);
    done_test("abort and restart");
    results();
  end
endmodule
`default_nettype wire
